// [rtl/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int N = 2
) (
	input  wire logic         clk_i,
	input  wire logic         arst_n_i,
	input  wire logic [N-1:0] d_i,
	output logic      [N-1:0] q_o
);
	if (N < 1) begin : g_chk
		$error("pin_sync needs at least one bit");
	end

	// a change counts once stages two and three agree
	for (genvar i = 0; i < N; i++) begin : g_bit
		logic s1_q;
		logic s2_q;
		logic s3_q;
		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				s1_q   <= 1'b1;
				s2_q   <= 1'b1;
				s3_q   <= 1'b1;
				q_o[i] <= 1'b1;
			end else begin
				s1_q <= d_i[i];
				s2_q <= s1_q;
				s3_q <= s2_q;
				if (s2_q == s3_q) begin
					q_o[i] <= s3_q;
				end
			end
		end
	end
endmodule : pin_sync
`default_nettype wire

// [rtl/rate_div.sv]
`timescale 1ns/1ps
`default_nettype none
module rate_div #(
	parameter int W = 8
) (
	input  wire logic         clk_i,
	input  wire logic         arst_n_i,
	input  wire logic [W-1:0] rate_i,
	output logic              tick_o
);
	logic [W-1:0] cnt_q;

	if (W < 1) begin : g_chk
		$error("rate_div needs a nonzero width");
	end

	// one tick every rate_i + 1 cycles
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_q  <= '0;
			tick_o <= 1'b0;
		end else if (cnt_q >= rate_i) begin
			cnt_q  <= '0;
			tick_o <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + W'(1);
			tick_o <= 1'b0;
		end
	end
endmodule : rate_div
`default_nettype wire

// [rtl/twb_pkg.sv]
package twb_pkg;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int BUS_FREE_NS   = 50000;
	localparam int START_DLY_NS  = 5000;
	localparam int FREE_CNT_W    = 10;
	localparam int DLY_CNT_W     = 7;
	localparam logic [FREE_CNT_W-1:0] BUS_FREE_CYC =
		FREE_CNT_W'((BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [DLY_CNT_W-1:0] START_DLY_CYC =
		DLY_CNT_W'((START_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ---------------------------------------------------------------
	// register selects and layout
	// ---------------------------------------------------------------
	localparam logic [2:0] SEL_CTRL   = 3'h0;
	localparam logic [2:0] SEL_RATE   = 3'h1;
	localparam logic [2:0] SEL_DATA   = 3'h2;
	localparam logic [2:0] SEL_ADDR   = 3'h3;
	localparam logic [2:0] SEL_STATUS = 3'h4;
	localparam int CTL_EN  = 6;
	localparam int CTL_STA = 5;
	localparam int CTL_STO = 4;
	localparam int CTL_SI  = 3;
	localparam int CTL_AA  = 2;
	localparam logic [7:0] CTL_RST  = 8'h00;
	localparam logic [7:0] RATE_RST = 8'h04;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] ADDR_RST = 8'h00;

	// ---------------------------------------------------------------
	// protocol state codes
	// ---------------------------------------------------------------
	localparam logic [7:0] ST_IDLE       = 8'hF8;
	localparam logic [7:0] ST_START      = 8'h08;
	localparam logic [7:0] ST_RSTART     = 8'h10;
	localparam logic [7:0] ST_MT_ADR_ACK = 8'h18;
	localparam logic [7:0] ST_MT_ADR_NAK = 8'h20;
	localparam logic [7:0] ST_MT_DAT_ACK = 8'h28;
	localparam logic [7:0] ST_MT_DAT_NAK = 8'h30;
	localparam logic [7:0] ST_ARB_LOST   = 8'h38;
	localparam logic [7:0] ST_MR_ADR_ACK = 8'h40;
	localparam logic [7:0] ST_MR_ADR_NAK = 8'h48;
	localparam logic [7:0] ST_MR_DAT_ACK = 8'h50;
	localparam logic [7:0] ST_MR_DAT_NAK = 8'h58;
	localparam logic [7:0] ST_SR_ADR     = 8'h60;
	localparam logic [7:0] ST_SR_GC      = 8'h70;
	localparam logic [7:0] ST_SR_DAT_ACK = 8'h80;
	localparam logic [7:0] ST_SR_DAT_NAK = 8'h88;
	localparam logic [7:0] ST_SR_STOP    = 8'hA0;
	localparam logic [7:0] ST_ST_ADR     = 8'hA8;
	localparam logic [7:0] ST_ST_DAT_ACK = 8'hB8;
	localparam logic [7:0] ST_ST_DAT_NAK = 8'hC0;

	typedef enum logic [3:0] {
		M_IDLE  = 4'h0,
		M_WAIT  = 4'h1,
		M_DLY   = 4'h3,
		M_START = 4'h2,
		M_HOLD  = 4'h6,
		M_LOW   = 4'h7,
		M_HIGH  = 4'h5,
		M_STOP1 = 4'h4,
		M_STOP2 = 4'hC,
		M_RS1   = 4'hD,
		M_RS2   = 4'hF
	} mst_state_type;

endpackage : twb_pkg

// [rtl/two_wire_ctrl.sv]
// Behaviour
// - software reads/writes all control bits
// - event flag set by hardware, cleared by software
// - stop flag cleared when bus STOP seen
// - enable bit off releases both bus lines
// - enable off/on resets all bus state
// - start flag enters master, START if free
// - busy bus: wait STOP, then 5 us
// - 50 us idle lines mean bus free
// - start after a byte gives repeated START
// - stop flag in master drives STOP
// - slave stop flag: internal stop, no drive
// - simulated stop keeps bus marked busy
// - each state entry sets flag, maybe interrupt
// - flag set and clock low: hold clock
// - ack flag selects ACK or NACK level
// - ack flag clear ignores own/general address
`timescale 1ns/1ps
`default_nettype none
module two_wire_ctrl
	import twb_pkg::*;
(
	input  wire logic       CLK_SYS_I,
	input  wire logic       ARST_N_I,
	input  wire logic [2:0] REG_SEL_I,
	input  wire logic       REG_WR_I,
	input  wire logic [7:0] REG_WDATA_I,
	output logic      [7:0] REG_RDATA_O,
	input  wire logic       INT_EN_I,
	output logic            IRQ_O,
	input  wire logic       SCL_I,
	output logic            SCL_O,
	output logic            SCL_OE_O,
	input  wire logic       SDA_I,
	output logic            SDA_O,
	output logic            SDA_OE_O
);
	// ---------------------------------------------------------------
	// line sampling
	// ---------------------------------------------------------------
	logic [1:0] pin_s;
	logic       scl_s, sda_s, scl_p_q, sda_p_q;
	logic       scl_rise, scl_fall, start_det, stop_det, tick;

	pin_sync #(.N(2)) u_sync (
		.clk_i    (CLK_SYS_I),
		.arst_n_i (ARST_N_I),
		.d_i      ({SCL_I, SDA_I}),
		.q_o      (pin_s)
	);

	assign scl_s     = pin_s[1];
	assign sda_s     = pin_s[0];
	assign scl_rise  = scl_s & ~scl_p_q;
	assign scl_fall  = ~scl_s & scl_p_q;
	assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;

	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [7:0] ctl_q, ctl_d, rate_q, data_q, addr_q, status_q, rdata_q;
	logic       en, start_request_flag, stop_request_flag, si, aa, ctl_wr, ev_set, sim_stop;
	logic       m_ev_q, s_ev_q, m_rx_load, s_rx_load, mst_q;
	logic [7:0] m_code_q, s_code_q, m_sh_q, sl_sh_q;

	assign en       = ctl_q[CTL_EN];
	assign start_request_flag      = ctl_q[CTL_STA];
	assign stop_request_flag      = ctl_q[CTL_STO];
	assign si       = ctl_q[CTL_SI];
	assign aa       = ctl_q[CTL_AA];
	assign ctl_wr   = REG_WR_I && (REG_SEL_I == SEL_CTRL);
	assign ev_set   = m_ev_q | s_ev_q;
	assign sim_stop = en & stop_request_flag & ~mst_q;

	always_comb begin
		ctl_d = ctl_wr ? REG_WDATA_I : ctl_q;
		if (!ctl_wr && (stop_det || sim_stop)) begin
			ctl_d[CTL_STO] = 1'b0;
		end
		ctl_d[CTL_SI] = ctl_d[CTL_SI] | ev_set;
	end

	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			ctl_q  <= CTL_RST;
			rate_q <= RATE_RST;
			addr_q <= ADDR_RST;
		end else begin
			ctl_q <= ctl_d;
			if (REG_WR_I && REG_SEL_I == SEL_RATE) begin
				rate_q <= REG_WDATA_I;
			end
			if (REG_WR_I && REG_SEL_I == SEL_ADDR) begin
				addr_q <= REG_WDATA_I;
			end
		end
	end

	// received bytes land in the data register; software write loses
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			data_q <= DATA_RST;
		end else if (m_rx_load) begin
			data_q <= m_sh_q;
		end else if (s_rx_load) begin
			data_q <= sl_sh_q;
		end else if (REG_WR_I && REG_SEL_I == SEL_DATA) begin
			data_q <= REG_WDATA_I;
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			status_q <= ST_IDLE;
		end else if (!en) begin
			status_q <= ST_IDLE;
		end else if (ev_set) begin
			status_q <= m_ev_q ? m_code_q : s_code_q;
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rdata_q <= 8'h00;
			IRQ_O   <= 1'b0;
		end else begin
			IRQ_O <= si & INT_EN_I;
			case (REG_SEL_I)
				SEL_CTRL:   rdata_q <= ctl_q;
				SEL_RATE:   rdata_q <= rate_q;
				SEL_DATA:   rdata_q <= data_q;
				SEL_ADDR:   rdata_q <= addr_q;
				SEL_STATUS: rdata_q <= status_q;
				default:    rdata_q <= 8'h00;
			endcase
		end
	end
	assign REG_RDATA_O = rdata_q;

	// ---------------------------------------------------------------
	// bus busy and free timeout
	// ---------------------------------------------------------------
	logic                  busy_q;
	logic [FREE_CNT_W-1:0] free_cnt_q;
	logic                  line_idle;
	assign line_idle = scl_s & sda_s;

	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			busy_q     <= 1'b0;
			free_cnt_q <= '0;
		end else if (!en) begin
			busy_q     <= 1'b0;
			free_cnt_q <= '0;
		end else begin
			free_cnt_q <= (busy_q && line_idle) ? free_cnt_q + FREE_CNT_W'(1) : '0;
			if (start_det) begin
				busy_q <= 1'b1;
			end else if (stop_det || (line_idle && free_cnt_q == BUS_FREE_CYC - FREE_CNT_W'(1))) begin
				busy_q <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// master engine
	// ---------------------------------------------------------------
	mst_state_type        m_st_q;
	logic [DLY_CNT_W-1:0] dly_q;
	logic [3:0]           m_cnt_q;
	logic                 m_ph_q, m_sda_q, bytes_q, adr_ph_q, rw_q, rx_now, bit_val, m_scl_low;

	rate_div #(.W(8)) u_div (
		.clk_i    (CLK_SYS_I),
		.arst_n_i (ARST_N_I),
		.rate_i   (rate_q),
		.tick_o   (tick)
	);

	assign rx_now    = rw_q & ~adr_ph_q;
	assign bit_val   = (m_cnt_q == 4'h8) ? (rx_now & aa) : (~rx_now & ~m_sh_q[7]);
	assign m_scl_low = (m_st_q == M_HOLD) || (m_st_q == M_LOW) || (m_st_q == M_STOP1) || (m_st_q == M_RS1);
	assign m_rx_load = en && m_st_q == M_HIGH && tick && scl_s && m_cnt_q == 4'h8 && rx_now;

	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			m_st_q <= M_IDLE; mst_q <= 1'b0; m_sda_q <= 1'b0; m_ph_q <= 1'b0;
			m_cnt_q <= 4'h0; m_sh_q <= 8'h00; dly_q <= '0; bytes_q <= 1'b0;
			adr_ph_q <= 1'b0; rw_q <= 1'b0; m_ev_q <= 1'b0; m_code_q <= ST_IDLE;
		end else if (!en) begin
			m_st_q <= M_IDLE; mst_q <= 1'b0; m_sda_q <= 1'b0; m_ph_q <= 1'b0;
			m_cnt_q <= 4'h0; bytes_q <= 1'b0; adr_ph_q <= 1'b0; m_ev_q <= 1'b0;
		end else begin
			m_ev_q <= 1'b0;
			case (m_st_q)
				M_IDLE: if (start_request_flag) begin
					mst_q   <= 1'b1;
					bytes_q <= 1'b0;
					m_ph_q  <= 1'b0;
					m_st_q  <= busy_q ? M_WAIT : M_START;
				end
				M_WAIT: if (!busy_q) begin
					dly_q  <= '0;
					m_st_q <= M_DLY;
				end
				M_DLY: if (busy_q) begin
					m_st_q <= M_WAIT;
				end else if (dly_q == START_DLY_CYC - DLY_CNT_W'(1)) begin
					m_st_q <= M_START;
				end else begin
					dly_q <= dly_q + DLY_CNT_W'(1);
				end
				M_START: if (tick) begin
					if (!m_ph_q) begin
						m_sda_q <= 1'b1;
						m_ph_q  <= 1'b1;
					end else begin
						m_st_q   <= M_HOLD;
						adr_ph_q <= 1'b1;
						m_ev_q   <= 1'b1;
						m_code_q <= bytes_q ? ST_RSTART : ST_START;
					end
				end
				M_HOLD: if (!si && !m_ev_q) begin
					m_ph_q <= 1'b0;
					if (stop_request_flag) begin
						m_st_q <= M_STOP1;
					end else if (start_request_flag && bytes_q) begin
						m_st_q <= M_RS1;
					end else begin
						m_st_q  <= M_LOW;
						m_cnt_q <= 4'h0;
						m_sh_q  <= data_q;
						if (adr_ph_q) begin
							rw_q <= data_q[0];
						end
					end
				end
				M_LOW: if (tick) begin
					// sda moves only a tick after scl fell
					if (!m_ph_q) begin
						m_sda_q <= bit_val;
						m_ph_q  <= 1'b1;
					end else begin
						m_ph_q <= 1'b0;
						m_st_q <= M_HIGH;
					end
				end
				M_HIGH: if (tick && scl_s) begin
					if (m_cnt_q == 4'h8) begin
						bytes_q  <= 1'b1;
						adr_ph_q <= 1'b0;
						m_st_q   <= M_HOLD;
						m_ev_q   <= 1'b1;
						if (adr_ph_q) begin
							m_code_q <= rw_q ? (sda_s ? ST_MR_ADR_NAK : ST_MR_ADR_ACK)
								: (sda_s ? ST_MT_ADR_NAK : ST_MT_ADR_ACK);
						end else begin
							m_code_q <= rw_q ? (aa ? ST_MR_DAT_ACK : ST_MR_DAT_NAK)
								: (sda_s ? ST_MT_DAT_NAK : ST_MT_DAT_ACK);
						end
					end else if (!rx_now && !m_sda_q && !sda_s) begin
						m_st_q   <= M_IDLE;
						mst_q    <= 1'b0;
						m_ev_q   <= 1'b1;
						m_code_q <= ST_ARB_LOST;
					end else begin
						m_sh_q  <= {m_sh_q[6:0], sda_s};
						m_cnt_q <= m_cnt_q + 4'h1;
						m_st_q  <= M_LOW;
					end
				end
				M_STOP1: if (tick) begin
					m_sda_q <= 1'b1;
					m_st_q  <= M_STOP2;
				end
				M_STOP2: if (tick && scl_s) begin
					m_sda_q <= 1'b0;
					mst_q   <= 1'b0;
					m_st_q  <= M_IDLE;
				end
				M_RS1: if (tick) begin
					m_sda_q <= 1'b0;
					m_st_q  <= M_RS2;
				end
				M_RS2: if (tick && scl_s) begin
					m_ph_q <= 1'b0;
					m_st_q <= M_START;
				end
				default: m_st_q <= M_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// slave engine
	// ---------------------------------------------------------------
	logic [3:0] sl_cnt_q;
	logic       sl_act_q, sl_adr_q, sl_tx_q, sl_ack_q, sl_mack_q, sl_gc_q, sl_new_q, s_sda_q;
	logic       adr_hit, gc_hit;
	// a cleared ack flag blinds both address matches
	assign adr_hit   = aa & (sl_sh_q[7:1] == addr_q[7:1]);
	assign gc_hit    = aa & addr_q[0] & (sl_sh_q[7:1] == 7'h00);
	assign s_rx_load = en && !mst_q && sl_act_q && sl_adr_q && !sl_tx_q && scl_fall && sl_cnt_q == 4'h8
		&& !start_det && !stop_det && !sim_stop;

	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			sl_cnt_q <= 4'h0; sl_act_q <= 1'b0; sl_adr_q <= 1'b0; sl_tx_q <= 1'b0;
			sl_ack_q <= 1'b0; sl_mack_q <= 1'b0; sl_gc_q <= 1'b0; sl_new_q <= 1'b0;
			sl_sh_q <= 8'h00; s_sda_q <= 1'b0; s_ev_q <= 1'b0; s_code_q <= ST_IDLE;
		end else if (!en || mst_q) begin
			sl_act_q <= 1'b0; sl_adr_q <= 1'b0; s_sda_q <= 1'b0; s_ev_q <= 1'b0;
		end else begin
			s_ev_q <= 1'b0;
			if (start_det || stop_det || sim_stop) begin
				if (sl_adr_q && !sim_stop) begin
					s_ev_q   <= 1'b1;
					s_code_q <= ST_SR_STOP;
				end
				sl_act_q <= start_det;
				sl_adr_q <= 1'b0;
				sl_cnt_q <= 4'h0;
				sl_ack_q <= 1'b0;
				s_sda_q  <= 1'b0;
			end else if (sl_act_q) begin
				if (scl_rise) begin
					if (sl_cnt_q < 4'h8) begin
						sl_sh_q <= {sl_sh_q[6:0], sda_s};
					end else begin
						sl_mack_q <= ~sda_s;
					end
					sl_cnt_q <= sl_cnt_q + 4'h1;
				end
				if (scl_fall && sl_cnt_q == 4'h8) begin
					if (!sl_adr_q) begin
						sl_adr_q <= adr_hit | gc_hit;
						sl_act_q <= adr_hit | gc_hit;
						sl_ack_q <= adr_hit | gc_hit;
						sl_tx_q  <= sl_sh_q[0];
						sl_gc_q  <= gc_hit & ~adr_hit;
						sl_new_q <= 1'b1;
					end else begin
						sl_ack_q <= ~sl_tx_q & aa;
					end
				end
				if (scl_fall && sl_cnt_q == 4'h9) begin
					sl_cnt_q <= 4'h0;
					sl_ack_q <= 1'b0;
					sl_new_q <= 1'b0;
					s_ev_q   <= 1'b1;
					if (sl_new_q) begin
						s_code_q <= sl_tx_q ? ST_ST_ADR : (sl_gc_q ? ST_SR_GC : ST_SR_ADR);
					end else if (sl_tx_q) begin
						s_code_q <= sl_mack_q ? ST_ST_DAT_ACK : ST_ST_DAT_NAK;
					end else begin
						s_code_q <= sl_ack_q ? ST_SR_DAT_ACK : ST_SR_DAT_NAK;
					end
					if (!sl_new_q && (sl_tx_q ? !sl_mack_q : !sl_ack_q)) begin
						sl_adr_q <= 1'b0;
						sl_act_q <= 1'b0;
					end
				end
				// data lines move only while scl is low
				if (!scl_s && !scl_fall) begin
					s_sda_q <= (sl_cnt_q == 4'h8) ? sl_ack_q
						: (sl_adr_q && sl_tx_q && sl_cnt_q < 4'h8 && !data_q[3'(4'h7 - sl_cnt_q)]);
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// pin drivers: open drain, enable pulls the line low
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			SCL_OE_O <= 1'b0;
			SDA_OE_O <= 1'b0;
			SCL_O    <= 1'b0;
			SDA_O    <= 1'b0;
		end else begin
			SCL_OE_O <= en & (m_scl_low | (si & ~scl_s));
			SDA_OE_O <= en & ((mst_q & m_sda_q) | (s_sda_q & ~sim_stop));
			SCL_O    <= 1'b0;
			SDA_O    <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!ARST_N_I);

	sequence hold_released;
		en && m_st_q == M_HOLD && !si && !m_ev_q;
	endsequence

	sw_write_back_a: assert property (
		ctl_wr |=> ctl_q[7:4] == $past(REG_WDATA_I[7:4]) && ctl_q[2:0] == $past(REG_WDATA_I[2:0])
	) else $error("control write not stored");
	flag_sticky_a: assert property (
		si && !(ctl_wr && !REG_WDATA_I[CTL_SI]) |=> si
	) else $error("event flag cleared without software");
	stop_clear_a: assert property (
		en && stop_det && !ctl_wr |=> !stop_request_flag
	) else $error("stop flag kept after bus stop");
	off_release_a: assert property (
		!en |=> !SCL_OE_O && !SDA_OE_O
	) else $error("lines driven while disabled");
	off_reset_a: assert property (
		!en |=> m_st_q == M_IDLE && !busy_q && !sl_adr_q
	) else $error("bus state kept while disabled");
	start_free_a: assert property (
		en && m_st_q == M_IDLE && start_request_flag && !busy_q |=> m_st_q == M_START && mst_q
	) else $error("no start on free bus");
	start_delay_a: assert property (
		en && m_st_q == M_WAIT && !busy_q |=> m_st_q == M_DLY && dly_q == '0
	) else $error("start delay not begun");
	free_timeout_a: assert property (
		en && busy_q && line_idle && free_cnt_q == BUS_FREE_CYC - FREE_CNT_W'(1) |=> !busy_q
	) else $error("bus not freed after idle time");
	rep_start_a: assert property (
		hold_released and (!stop_request_flag && start_request_flag && bytes_q) |=> m_st_q == M_RS1 ##[1:600] m_st_q == M_RS2
	) else $error("no repeated start");
	stop_drive_a: assert property (
		hold_released and stop_request_flag |=> m_st_q == M_STOP1
	) else $error("no stop from master");
	sim_stop_a: assert property (
		sim_stop && !ctl_wr |=> !sl_adr_q && !stop_request_flag && !SDA_OE_O
	) else $error("simulated stop misbehaved");
	sim_busy_a: assert property (
		sim_stop && busy_q && !stop_det && free_cnt_q != BUS_FREE_CYC - FREE_CNT_W'(1) |=> busy_q
	) else $error("simulated stop freed the bus");
	event_irq_a: assert property (
		ev_set && INT_EN_I |=> si ##1 IRQ_O
	) else $error("event did not raise flag and request");
	stretch_a: assert property (
		en && si && !scl_s |=> SCL_OE_O
	) else $error("clock not held while flag set");
	ack_level_a: assert property (
		en && !mst_q && sl_act_q && sl_adr_q && !sl_tx_q && scl_fall && sl_cnt_q == 4'h8
			&& !start_det && !stop_det && !sim_stop |=> sl_ack_q == $past(aa)
	) else $error("ack level does not follow flag");
	adr_ignore_a: assert property (
		en && !mst_q && sl_act_q && !sl_adr_q && scl_fall && sl_cnt_q == 4'h8 && !aa
			&& !start_det && !stop_det && !sim_stop |=> !sl_adr_q && !sl_act_q
	) else $error("address seen while ack flag clear");
endmodule : two_wire_ctrl
`default_nettype wire

// [tb/bus_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_pull_o,
	output logic      sda_pull_o
);
	// ---------------------------------------------------------------
	// other party on the wire
	// ---------------------------------------------------------------
	int   n_start    = 0;
	int   n_stop     = 0;
	int   bits       = 0;
	int   stretch_ns = 0;
	logic mst        = 1'b0;

	initial begin
		scl_pull_o = 1'b0;
		sda_pull_o = 1'b0;
	end

	always @(negedge sda_i) if (scl_i === 1'b1) begin
		n_start++;
		bits = 0;
	end
	always @(posedge sda_i) if (scl_i === 1'b1) n_stop++;
	always @(posedge scl_i) bits++;

	// ack every ninth clock as an addressed slave would
	always @(negedge scl_i) if (!mst) begin
		sda_pull_o = (bits == 8);
		if (bits == 9) bits = 0;
	end

	// slow answer: clock held low after each fall
	always @(negedge scl_i) if (stretch_ns > 0 && !mst) begin
		scl_pull_o = 1'b1;
		#(stretch_ns) scl_pull_o = 1'b0;
	end

	// rival master: sda released first so no stop appears
	task bus_start();
		mst = 1'b1;
		sda_pull_o = 1'b1;
		#200 scl_pull_o = 1'b1;
		#200;
	endtask : bus_start

	task bus_release();
		sda_pull_o = 1'b0;
		#200 scl_pull_o = 1'b0;
		#200 mst = 1'b0;
	endtask : bus_release

	// master side byte, msb first; edges kept off the sampling edge
	task send_byte(input logic [7:0] b, output logic ack);
		int i;
		for (i = 7; i >= 0; i--) begin
			sda_pull_o = ~b[i];
			#400 scl_pull_o = 1'b0;
			wait (scl_i === 1'b1);
			#410 scl_pull_o = 1'b1;
			#100;
		end
		sda_pull_o = 1'b0;
		#400 scl_pull_o = 1'b0;
		wait (scl_i === 1'b1);
		#210 ack = !sda_i;
		#200 scl_pull_o = 1'b1;
		#100;
	endtask : send_byte
endmodule : bus_partner
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench
	import twb_pkg::*;
;
	logic       clk;
	logic       arst_n;
	logic       reg_wr;
	logic       int_en;
	logic [2:0] reg_sel;
	logic [7:0] wdata;
	wire  logic [7:0] rdata;
	wire  logic irq, scl_oe, sda_oe, scl_pull, sda_pull, scl_o, sda_o;
	wire  logic scl = !scl_oe && !scl_pull;
	wire  logic sda = !sda_oe && !sda_pull;
	int         num_errors = 0;
	int         cmp_count  = 0;

	two_wire_ctrl two_wire_ctrl_i (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .REG_SEL_I(reg_sel),
		.REG_WR_I(reg_wr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .INT_EN_I(int_en),
		.IRQ_O(irq), .SCL_I(scl), .SCL_O(scl_o), .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(sda_o),
		.SDA_OE_O(sda_oe));
	bus_partner bus_partner_i (.scl_i(scl), .sda_i(sda), .scl_pull_o(scl_pull), .sda_pull_o(sda_pull));

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task wr(input logic [2:0] s, input logic [7:0] d);
		@(negedge clk);
		reg_sel = s;
		wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr

	task rchk(input string nm, input logic [2:0] s, input logic [7:0] e);
		@(negedge clk);
		reg_sel = s;
		repeat (2) @(negedge clk);
		chk(nm, e, rdata);
	endtask : rchk

	// irq doubles as the event flag while the interrupt is enabled
	// two edges first: irq lags a clearing write by one cycle
	task wait_irq(input int n);
		int i;
		repeat (2) @(negedge clk);
		for (i = 0; i < n && irq !== 1'b1; i++) @(negedge clk);
		chk("irq", 8'h01, {7'h00, irq});
	endtask : wait_irq

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task t_regs();
		rchk("ctl", SEL_CTRL, CTL_RST);
		rchk("rate", SEL_RATE, RATE_RST);
		rchk("status", SEL_STATUS, ST_IDLE);
		rchk("unmapped", 3'h5, 8'h00);
		wr(SEL_CTRL, 8'hA7);
		rchk("ctl", SEL_CTRL, 8'hA7);
	endtask : t_regs

	task t_event();
		wr(SEL_CTRL, 8'h08);
		repeat (2) @(negedge clk);
		chk("irq", 8'h01, {7'h00, irq});
		int_en = 1'b0;
		repeat (2) @(negedge clk);
		chk("irq", 8'h00, {7'h00, irq});
		int_en = 1'b1;
		rchk("ctl", SEL_CTRL, 8'h08);
		wr(SEL_CTRL, 8'h00);
		rchk("ctl", SEL_CTRL, 8'h00);
	endtask : t_event

	task t_master();
		int s;
		s = bus_partner_i.n_start;
		bus_partner_i.stretch_ns = 800;
		wr(SEL_DATA, 8'hA0);
		wr(SEL_CTRL, 8'h64);
		wait_irq(3000);
		rchk("status", SEL_STATUS, ST_START);
		chk("starts", 8'h01, 8'(bus_partner_i.n_start - s));
		chk("scl_hold", 8'h01, {7'h00, scl_oe});
		wr(SEL_CTRL, 8'h44);
		wait_irq(3000);
		rchk("status", SEL_STATUS, ST_MT_ADR_ACK);
		wr(SEL_CTRL, 8'h64);
		wait_irq(3000);
		rchk("status", SEL_STATUS, ST_RSTART);
		wr(SEL_DATA, 8'hA0);
		wr(SEL_CTRL, 8'h44);
		wait_irq(3000);
		s = bus_partner_i.n_stop;
		wr(SEL_CTRL, 8'h54);
		repeat (400) @(negedge clk);
		chk("stops", 8'h01, 8'(bus_partner_i.n_stop - s));
		rchk("ctl", SEL_CTRL, 8'h44);
		bus_partner_i.stretch_ns = 0;
	endtask : t_master

	task t_disable();
		wr(SEL_CTRL, 8'h64);
		wait_irq(3000);
		wr(SEL_CTRL, 8'h00);
		repeat (2) @(negedge clk);
		chk("oe", 8'h00, {6'h00, scl_oe, sda_oe});
		chk("out_lvl", 8'h00, {6'h00, scl_o, sda_o});
		wr(SEL_CTRL, 8'h44);
		rchk("status", SEL_STATUS, ST_IDLE);
	endtask : t_disable

	// busy bus with lines left idle: only the free timeout may let us start
	task t_busy();
		int i;
		logic drove;
		bus_partner_i.bus_start();
		wr(SEL_CTRL, 8'h54);
		repeat (4) @(negedge clk);
		rchk("ctl", SEL_CTRL, 8'h44);
		chk("sda_oe", 8'h00, {7'h00, sda_oe});
		bus_partner_i.bus_release();
		wr(SEL_CTRL, 8'h64);
		drove = 1'b0;
		for (i = 0; i < 900; i++) begin
			@(negedge clk);
			if (sda_oe !== 1'b0) drove = 1'b1;
		end
		chk("early_start", 8'h00, {7'h00, drove});
		wait_irq(1500);
		rchk("status", SEL_STATUS, ST_START);
		wr(SEL_CTRL, 8'h00);
	endtask : t_busy

	// partner as master: address match, refused data, ignored address
	task t_slave();
		logic ack;
		wr(SEL_ADDR, 8'h42);
		wr(SEL_CTRL, 8'h44);
		bus_partner_i.bus_start();
		bus_partner_i.send_byte(8'h42, ack);
		chk("adr_ack", 8'h01, {7'h00, ack});
		wait_irq(200);
		rchk("status", SEL_STATUS, ST_SR_ADR);
		chk("scl_hold", 8'h01, {7'h00, scl_oe});
		wr(SEL_CTRL, 8'h40);
		bus_partner_i.send_byte(8'h5A, ack);
		chk("dat_ack", 8'h00, {7'h00, ack});
		wait_irq(200);
		rchk("status", SEL_STATUS, ST_SR_DAT_NAK);
		rchk("data", SEL_DATA, 8'h5A);
		wr(SEL_CTRL, 8'h40);
		bus_partner_i.bus_release();
		bus_partner_i.bus_start();
		bus_partner_i.send_byte(8'h42, ack);
		chk("ign_ack", 8'h00, {7'h00, ack});
		repeat (20) @(negedge clk);
		chk("irq", 8'h00, {7'h00, irq});
		bus_partner_i.bus_release();
		wr(SEL_CTRL, 8'h00);
	endtask : t_slave

	task complete_run();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// whole run is a few thousand cycles; this is 60000 cycles, about twenty times that
	initial begin
		#3000000;
		num_errors++;
		complete_run();
	end

	initial begin
		arst_n = 1'b0;
		reg_wr = 1'b0;
		int_en = 1'b1;
		reg_sel = 3'h0;
		wdata = 8'h00;
		repeat (6) @(negedge clk);
		arst_n = 1'b1;
		t_regs();
		t_event();
		t_master();
		t_disable();
		t_busy();
		t_slave();
		complete_run();
	end
endmodule : testbench
`default_nettype wire
